// *** rtl/mto_pkg.sv ***
// Constants, types and register map of the motor thermal overload block.
package mto_pkg;
  // Clock and thermal step timing.
  localparam int CLK_NS = 40;
  localparam longint TICK_NS = 64'd10000000;
  localparam int TICK_CYC = int'((TICK_NS + CLK_NS - 1) / CLK_NS);
  localparam int TICKS_PER_SEC = 100;
  localparam int LOCK_SEC = 10;
  localparam int CLEAR_MIN = 10;
  localparam logic [15:0] LOCK_TICKS = 16'(LOCK_SEC * TICKS_PER_SEC);
  localparam logic [15:0] CLEAR_TICKS = 16'(CLEAR_MIN * 60 * TICKS_PER_SEC);

  // Current scale: 12'h400 is the drive's rated current.
  localparam logic [11:0] RATED = 12'h400;
  localparam logic [11:0] THR_MIN = 12'h0CD;
  localparam logic [11:0] THR_MAX = 12'h400;
  localparam logic [11:0] FM_CUR_MIN = 12'h148;
  localparam logic [11:0] FM_CUR_MAX = 12'hCCD;
  // Deceleration rate in 0.1 s steps.
  localparam logic [14:0] FM_DEC_MIN = 15'h0001;
  localparam logic [14:0] FM_DEC_MAX = 15'h7530;
  localparam logic [14:0] FM_DEC_RST = 15'h0005;
  // Frequencies in 0.01 Hz.
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  // Decrement times in 0.01 s, which is one thermal step.
  localparam logic [23:0] DEC_T_MIN = 24'h00000A;
  localparam logic [23:0] DEC_T_MAX = 24'h989680;
  localparam logic [23:0] DEC_T_RST = 24'h00EA60;
  localparam logic [23:0] TAU_RST = 24'h003A98;
  // Accumulation gain in 0.1 %.
  localparam logic [10:0] GAIN_MIN = 11'h00A;
  localparam logic [10:0] GAIN_MAX = 11'h7D0;
  localparam logic [10:0] GAIN_RST = 11'h3E8;
  // Accumulator full scale; chosen so that one fixed linear step is 1/60000 of it.
  localparam logic [23:0] ACC_FULL = 24'hEA6000;
  localparam logic [23:0] LIN_STEP = 24'h000100;
  // Derating knees and factors (factor 11'h400 = 100 %).
  localparam logic [15:0] RT_KNEE = 16'h07D0;
  localparam logic [10:0] RT_FACT = 11'h334;
  localparam logic [15:0] CT_KNEE = 16'h012C;
  localparam logic [10:0] CT_FACT = 11'h39A;
  // Fault history codes.
  localparam logic [7:0] ERR_MOTOR = 8'h05;
  localparam logic [7:0] ERR_DRIVE = 8'h26;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THR1 = 8'h04;
  localparam logic [7:0] OFS_CURVE1 = 8'h08;
  localparam logic [7:0] OFS_THR2 = 8'h0C;
  localparam logic [7:0] OFS_CURVE2 = 8'h10;
  localparam logic [7:0] OFS_DMODE = 8'h14;
  localparam logic [7:0] OFS_DTIME = 8'h18;
  localparam logic [7:0] OFS_TAU = 8'h1C;
  localparam logic [7:0] OFS_GAIN = 8'h20;
  localparam logic [7:0] OFS_PT1 = 8'h24;
  localparam logic [7:0] OFS_PT2 = 8'h28;
  localparam logic [7:0] OFS_PT3 = 8'h2C;
  localparam logic [7:0] OFS_FMCUR = 8'h30;
  localparam logic [7:0] OFS_FMDEC = 8'h34;
  localparam logic [7:0] OFS_FMSEL = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3C;
  localparam logic [7:0] OFS_FAULT = 8'h40;
  localparam logic [7:0] OFS_MACC = 8'h44;
  localparam logic [7:0] OFS_DACC = 8'h48;
  // Control register bit positions.
  localparam int CTRL_SEL2 = 0;
  localparam int CTRL_RESET = 1;

  typedef enum logic [1:0] {CURVE_REDUCED, CURVE_CONST, CURVE_FREE} mto_curve_t;
  typedef enum logic [1:0] {DEC_OFF, DEC_FIXED, DEC_LINTIME, DEC_TAU} mto_dmode_t;
  typedef enum logic [1:0] {START_INTERRUPT, START_MAX, START_SET} mto_start_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [11:0] cur;
  } mto_point_t;

  typedef struct packed {
    logic [11:0] level;
    logic [14:0] decel;
    mto_start_t start_sel;
  } mto_fm_cfg_t;
endpackage

// *** rtl/mto_top.sv ***
// Motor and drive electronic thermal overload protection with an AHB-Lite register slave.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// (R1) Motor threshold clamped to 20..100 % rated.
// (R2) Trip turns motor output off, logs fault.
// (R3) Motor and drive trips use distinct codes.
// (R4) Drive model: constant torque, rated current.
// (R5) Curve code: reduced, constant or free.
// (R6) Free curve: three points, top 400 Hz.
// (R7) Second motor has own threshold and curve.
// (R8) Mode zero matches the drive's own model.
// (R9) Above threshold, rise proportional to overload.
// (R10) Accumulator at full scale trips the motor.
// (R11) Reset ignored for ten seconds after trip.
// (R12) Mode zero clears periodically, on reset.
// (R13) Fixed linear mode ramps down below threshold.
// (R14) Fixed ramp: full scale per ten minutes.
// (R15) Linear-time mode uses programmable decrement time.
// (R16) Time-constant mode decays exponentially.
// (R17) Restart current 0.32..3.20 times rated.
// (R18) Restart deceleration 0.1..3000 s, default 0.5.
// (R19) Restart start frequency chosen by code.
// (R20) Threshold at full load protects near 115 %.
// (R21) Saturate at zero; motor accumulator holds full scale while tripped.
module mto_top #(
  parameter int TICK_CYCLES = mto_pkg::TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [11:0] output_current,
  input wire logic [15:0] output_freq,
  output logic motor_output_en,
  output logic motor_trip,
  output logic drive_trip,
  output mto_pkg::mto_fm_cfg_t fm_cfg
);
  import mto_pkg::*;

  // All assertions below share the bus clock and are off while reset is held.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [11:0] thr1_q, thr2_q;
  mto_curve_t curve1_q, curve2_q;
  mto_dmode_t dmode_q;
  logic sel2_q;
  logic [23:0] dtime_q, tau_q;
  logic [10:0] gain_q;
  mto_point_t pt1_q, pt2_q, pt3_q;
  mto_fm_cfg_t fm_q;
  logic [23:0] macc_q, dacc_q;
  logic motor_trip_q, drive_trip_q;
  logic [15:0] lock_q, clr_cnt_q;
  logic [7:0] fault_code_q, fault_cnt_q;
  logic [17:0] div_q;
  logic tick;
  logic wr_q, rd_q;
  logic [7:0] addr_q;
  logic reset_req, reset_ok, clr_pulse;
  logic [11:0] thr_eff, mlevel, dlevel;
  mto_curve_t curve_eff;
  logic [23:0] mstep, mnext, dnext;
  logic mover;

  // Keep a setting inside its legal window.
  function automatic logic [23:0] clamp(input logic [23:0] v, input logic [23:0] lo,
                                        input logic [23:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Scale a current by a 1/1024 factor.
  function automatic logic [11:0] scale(input logic [11:0] c, input logic [11:0] f);
    logic [23:0] p;
    p = c * f;
    scale = p[21:10];
  endfunction

  // Frequency-derated protection level for the chosen curve.
  function automatic logic [11:0] level_for(input logic [11:0] thr, input mto_curve_t cv,
                                            input logic [15:0] f);
    logic [11:0] lv;
    lv = thr;
    unique case (cv)
      CURVE_REDUCED: if (f < RT_KNEE) lv = scale(thr, {1'b0, RT_FACT});
      CURVE_CONST: if (f < CT_KNEE) lv = scale(thr, {1'b0, CT_FACT});
      // Points are searched in order, so misordered points collapse safely.
      CURVE_FREE: begin
        if (f <= pt1_q.freq) begin
          lv = scale(thr, pt1_q.cur); // R6
        end else if (f <= pt2_q.freq) begin
          lv = scale(thr, pt2_q.cur);
        end else begin
          lv = scale(thr, pt3_q.cur);
        end
      end
      default: lv = thr;
    endcase
    level_for = lv;
  endfunction

  // One thermal step: rise on overload, otherwise fall by step, floored at zero.
  function automatic logic [23:0] therm_next(input logic [23:0] acc, input logic [11:0] cur,
                                             input logic [11:0] lv, input logic [10:0] gain,
                                             input logic [23:0] step);
    logic [24:0] sum;
    logic [22:0] inc;
    logic [22:0] prod;
    prod = 23'((cur - lv) * gain);
    inc = {2'b00, prod[22:2]};
    sum = {1'b0, acc} + {2'b00, inc};
    if (cur > lv) begin
      therm_next = (sum >= {1'b0, ACC_FULL}) ? ACC_FULL : sum[23:0]; // R9
    end else begin
      therm_next = (acc > step) ? acc - step : 24'h000000; // R21
    end
  endfunction

  // Register read mux; unmapped offsets read as zero.
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      OFS_CTRL: rd_mux = {31'h0, sel2_q};
      OFS_THR1: rd_mux = {20'h0, thr1_q};
      OFS_CURVE1: rd_mux = {30'h0, curve1_q};
      OFS_THR2: rd_mux = {20'h0, thr2_q};
      OFS_CURVE2: rd_mux = {30'h0, curve2_q};
      OFS_DMODE: rd_mux = {30'h0, dmode_q};
      OFS_DTIME: rd_mux = {8'h0, dtime_q};
      OFS_TAU: rd_mux = {8'h0, tau_q};
      OFS_GAIN: rd_mux = {21'h0, gain_q};
      OFS_PT1: rd_mux = {4'h0, pt1_q};
      OFS_PT2: rd_mux = {4'h0, pt2_q};
      OFS_PT3: rd_mux = {4'h0, pt3_q};
      OFS_FMCUR: rd_mux = {20'h0, fm_q.level};
      OFS_FMDEC: rd_mux = {17'h0, fm_q.decel};
      OFS_FMSEL: rd_mux = {30'h0, fm_q.start_sel};
      OFS_STATUS: rd_mux = {28'h0, sel2_q, (lock_q != 16'h0000), drive_trip_q, motor_trip_q};
      OFS_FAULT: rd_mux = {16'h0, fault_cnt_q, fault_code_q};
      OFS_MACC: rd_mux = {8'h0, macc_q};
      OFS_DACC: rd_mux = {8'h0, dacc_q};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  // Bus address phase. The slave never inserts waits, so hreadyout is always high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      rd_q <= hsel & htrans[1] & ~hwrite;
      addr_q <= {haddr[7:2], 2'b00};
    end
  end

  // Zero-wait OKAY slave; the read mux is a process so it follows every register it reads.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_comb begin
    hrdata = rd_q ? rd_mux(addr_q) : 32'h00000000;
  end

  // Configuration writes, clamped to the legal ranges as they land.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel2_q <= 1'b0;
      thr1_q <= RATED;
      thr2_q <= RATED;
      curve1_q <= CURVE_REDUCED;
      curve2_q <= CURVE_REDUCED;
      dmode_q <= DEC_OFF;
      dtime_q <= DEC_T_RST;
      tau_q <= TAU_RST;
      gain_q <= GAIN_RST;
      pt1_q <= '0;
      pt2_q <= '0;
      pt3_q <= '0;
      fm_q.level <= RATED;
      fm_q.decel <= FM_DEC_RST;
      fm_q.start_sel <= START_INTERRUPT;
    end else if (wr_q) begin
      unique case (addr_q)
        OFS_CTRL: sel2_q <= hwdata[CTRL_SEL2];
        OFS_THR1: thr1_q <= 12'(clamp({12'h0, hwdata[11:0]}, {12'h0, THR_MIN},
                                      {12'h0, THR_MAX})); // R1
        OFS_THR2: thr2_q <= 12'(clamp({12'h0, hwdata[11:0]}, {12'h0, THR_MIN},
                                      {12'h0, THR_MAX})); // R7
        OFS_CURVE1: curve1_q <= (hwdata[1:0] == 2'b11) ? CURVE_FREE
                                                       : mto_curve_t'(hwdata[1:0]); // R5
        OFS_CURVE2: curve2_q <= (hwdata[1:0] == 2'b11) ? CURVE_FREE
                                                       : mto_curve_t'(hwdata[1:0]);
        OFS_DMODE: dmode_q <= mto_dmode_t'(hwdata[1:0]);
        OFS_DTIME: dtime_q <= clamp(hwdata[23:0], DEC_T_MIN, DEC_T_MAX); // R15
        OFS_TAU: tau_q <= clamp(hwdata[23:0], DEC_T_MIN, DEC_T_MAX); // R16
        OFS_GAIN: gain_q <= 11'(clamp({13'h0, hwdata[10:0]}, {13'h0, GAIN_MIN},
                                      {13'h0, GAIN_MAX}));
        OFS_PT1: pt1_q <= {16'(clamp({8'h0, hwdata[27:12]}, 24'h0, {8'h0, FREQ_MAX})),
                           12'(clamp({12'h0, hwdata[11:0]}, 24'h0, {12'h0, RATED}))};
        OFS_PT2: pt2_q <= {16'(clamp({8'h0, hwdata[27:12]}, 24'h0, {8'h0, FREQ_MAX})),
                           12'(clamp({12'h0, hwdata[11:0]}, 24'h0, {12'h0, RATED}))};
        OFS_PT3: pt3_q <= {16'(clamp({8'h0, hwdata[27:12]}, 24'h0, {8'h0, FREQ_MAX})),
                           12'(clamp({12'h0, hwdata[11:0]}, 24'h0, {12'h0, RATED}))}; // R6
        OFS_FMCUR: fm_q.level <= 12'(clamp({12'h0, hwdata[11:0]}, {12'h0, FM_CUR_MIN},
                                           {12'h0, FM_CUR_MAX})); // R17
        OFS_FMDEC: fm_q.decel <= 15'(clamp({9'h0, hwdata[14:0]}, {9'h0, FM_DEC_MIN},
                                           {9'h0, FM_DEC_MAX})); // R18
        OFS_FMSEL: fm_q.start_sel <= (hwdata[1:0] == 2'b11) ? START_SET
                                                            : mto_start_t'(hwdata[1:0]); // R19
        default: ;
      endcase
    end
  end

  assign fm_cfg = fm_q;

  // Thermal step divider: one enable pulse every 10 ms.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 18'h00000;
    end else begin
      div_q <= tick ? 18'h00000 : div_q + 18'h00001;
    end
  end
  assign tick = (div_q == 18'(TICK_CYCLES - 1));

  // Active motor set, its derated level and the decrement step of the chosen mode.
  assign thr_eff = sel2_q ? thr2_q : thr1_q; // R7
  assign curve_eff = sel2_q ? curve2_q : curve1_q;
  // With the threshold at full-load current, a steady 115 % load trips within seconds.
  // A process, not an assign, so that writes to the free-curve points are followed.
  always_comb begin
    mlevel = level_for(thr_eff, curve_eff, output_freq); // R20
    dlevel = level_for(RATED, CURVE_CONST, output_freq); // R4
  end
  assign mover = output_current > mlevel;
  always_comb begin
    unique case (dmode_q)
      DEC_OFF: mstep = 24'h000000; // R8
      DEC_FIXED: mstep = LIN_STEP; // R13 R14
      DEC_LINTIME: mstep = ACC_FULL / dtime_q; // R15
      DEC_TAU: mstep = (macc_q < tau_q) ? {23'h0, (macc_q != 24'h0)} : macc_q / tau_q; // R16
    endcase
  end
  assign mnext = therm_next(macc_q, output_current, mlevel, gain_q, mstep);
  assign dnext = therm_next(dacc_q, output_current, dlevel, GAIN_RST, 24'h000000); // R8

  // A reset command counts only once the lockout has run out.
  assign reset_req = wr_q & (addr_q == OFS_CTRL) & hwdata[CTRL_RESET];
  assign reset_ok = reset_req & (lock_q == 16'h0000); // R11
  assign clr_pulse = tick & (clr_cnt_q == CLEAR_TICKS - 16'h0001);

  // Ten-minute clearing cycle of the no-decrement model.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_cnt_q <= 16'h0000;
    end else if (tick) begin
      clr_cnt_q <= clr_pulse ? 16'h0000 : clr_cnt_q + 16'h0001; // R12
    end
  end

  // Motor accumulator and trip. A new trip is applied after a clear, so it is never lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      macc_q <= 24'h000000;
      motor_trip_q <= 1'b0;
    end else begin
      if (reset_ok) begin
        macc_q <= 24'h000000; // R12
        motor_trip_q <= 1'b0;
      end else if (motor_trip_q) begin
        macc_q <= ACC_FULL; // R21
      end else if (clr_pulse && dmode_q == DEC_OFF) begin
        macc_q <= 24'h000000; // R12
      end else if (tick) begin
        macc_q <= mnext;
      end
      if (tick && !motor_trip_q && mnext >= ACC_FULL) begin
        macc_q <= ACC_FULL;
        motor_trip_q <= 1'b1; // R10
      end
    end
  end

  // Drive accumulator, always in the no-decrement form at rated current.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dacc_q <= 24'h000000;
      drive_trip_q <= 1'b0;
    end else begin
      if (reset_ok || clr_pulse) begin
        dacc_q <= 24'h000000;
        drive_trip_q <= drive_trip_q & ~reset_ok;
      end else if (drive_trip_q) begin
        dacc_q <= ACC_FULL;
      end else if (tick) begin
        dacc_q <= dnext;
      end
      if (tick && !drive_trip_q && dnext >= ACC_FULL) begin
        dacc_q <= ACC_FULL;
        drive_trip_q <= 1'b1; // R4
      end
    end
  end

  // Lockout timer and fault history; a motor trip wins the log if both land together.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 16'h0000;
      fault_code_q <= 8'h00;
      fault_cnt_q <= 8'h00;
    end else begin
      if (tick && lock_q != 16'h0000) begin
        lock_q <= lock_q - 16'h0001;
      end
      if (tick && !motor_trip_q && mnext >= ACC_FULL) begin
        lock_q <= LOCK_TICKS; // R11
        fault_code_q <= ERR_MOTOR; // R3
        fault_cnt_q <= fault_cnt_q + 8'h01; // R2
      end else if (tick && !drive_trip_q && dnext >= ACC_FULL) begin
        lock_q <= LOCK_TICKS;
        fault_code_q <= ERR_DRIVE; // R3
        fault_cnt_q <= fault_cnt_q + 8'h01;
      end
    end
  end

  // Output stage is gated off by either trip.
  assign motor_output_en = ~(motor_trip_q | drive_trip_q); // R2
  assign motor_trip = motor_trip_q;
  assign drive_trip = drive_trip_q;

  thr_range_a: assert property ( // R1
    thr1_q >= THR_MIN && thr1_q <= THR_MAX && thr2_q >= THR_MIN && thr2_q <= THR_MAX)
    else $error("thermal threshold out of range");
  trip_off_a: assert property ( // R2
    motor_trip_q |-> !motor_output_en)
    else $error("motor output on while tripped");
  motor_code_a: assert property ( // R3
    $rose(motor_trip_q) |-> fault_code_q == ERR_MOTOR && fault_cnt_q == $past(fault_cnt_q) + 8'h01)
    else $error("motor trip not logged");
  drive_code_a: assert property ( // R4
    $rose(drive_trip_q) && !$rose(motor_trip_q) |-> fault_code_q == ERR_DRIVE)
    else $error("drive trip not logged");
  free_top_a: assert property ( // R6
    pt3_q.freq <= FREQ_MAX)
    else $error("free curve frequency above limit");
  full_trip_a: assert property ( // R10
    tick && !motor_trip_q && !reset_ok && mnext >= ACC_FULL |=> motor_trip_q)
    else $error("full scale did not trip");
  lock_hold_a: assert property ( // R11
    motor_trip_q && reset_req && lock_q != 16'h0000 |=> motor_trip_q)
    else $error("reset accepted inside lockout");
  lock_load_a: assert property ( // R11
    $rose(motor_trip_q) |-> lock_q == LOCK_TICKS)
    else $error("lockout not loaded");
  period_clr_a: assert property ( // R12
    clr_pulse && dmode_q == DEC_OFF && !motor_trip_q && !mover |=> macc_q == 24'h000000)
    else $error("periodic clear missed");
  fixed_step_a: assert property ( // R14
    tick && dmode_q == DEC_FIXED && !mover && !motor_trip_q && !reset_ok && !clr_pulse
      && macc_q >= LIN_STEP |=> macc_q == $past(macc_q) - LIN_STEP)
    else $error("fixed ramp step wrong");
  rise_a: assert property ( // R9
    tick && mover && !motor_trip_q && !reset_ok && !(clr_pulse && dmode_q == DEC_OFF)
      && macc_q < ACC_FULL |=> macc_q > $past(macc_q) || motor_trip_q)
    else $error("accumulator did not rise on overload");
  full_hold_a: assert property ( // R21
    motor_trip_q |-> macc_q == ACC_FULL)
    else $error("accumulator left full scale while tripped");
  fm_range_a: assert property ( // R17
    fm_q.level >= FM_CUR_MIN && fm_q.level <= FM_CUR_MAX && fm_q.decel >= FM_DEC_MIN
      && fm_q.decel <= FM_DEC_MAX)
    else $error("restart setting out of range");
endmodule

// *** bench/mto_motor_model.sv ***
// Behavioural inverter power stage that feeds motor current and frequency to the block.
`timescale 1ns/1ps
module mto_motor_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic motor_output_en,
  input wire logic [11:0] demand,
  input wire logic [15:0] freq_set,
  output logic [11:0] output_current,
  output logic [15:0] output_freq
);
  // A disabled stage carries no current, so a trip really removes the load.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_current <= 12'h000;
      output_freq <= 16'h0000;
    end else begin
      output_current <= motor_output_en ? demand : 12'h000;
      output_freq <= motor_output_en ? freq_set : 16'h0000;
    end
  end
endmodule

// *** bench/mto_top_tb.sv ***
// Self-checking testbench of the motor thermal overload block.
`timescale 1ns/1ps
module mto_top_tb;
  import mto_pkg::*;
  // Short thermal tick keeps the ten second lockout near 4000 cycles.
  localparam int TK = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic motor_output_en, motor_trip, drive_trip;
  logic [31:0] haddr, hwdata, hrdata, rv, a, b;
  logic [1:0] htrans;
  logic [11:0] output_current, demand;
  logic [15:0] output_freq, freq_set;
  mto_fm_cfg_t fm_cfg;
  int miscompares, samples_checked, cycles;

  mto_top #(.TICK_CYCLES(TK)) mto_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .output_current(output_current), .output_freq(output_freq),
    .motor_output_en(motor_output_en), .motor_trip(motor_trip), .drive_trip(drive_trip),
    .fm_cfg(fm_cfg));
  mto_motor_model mto_motor_model_inst (.clk(hclk), .rst_n(hresetn),
    .motor_output_en(motor_output_en), .demand(demand), .freq_set(freq_set),
    .output_current(output_current), .output_freq(output_freq));

  // Free-running clock at 25 MHz.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Hang guard; the whole run needs roughly 5000 cycles.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; the address phase is held until hready is seen.
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d, rv);
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, rv);
    chk(rv, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge hclk);
  endtask

  // Two accumulator samples exactly one thermal tick apart.
  task automatic tick_pair(output logic [31:0] x, output logic [31:0] y);
    xfer(1'b0, OFS_MACC, 32'h0, x);
    repeat (TK - 3) @(posedge hclk);
    xfer(1'b0, OFS_MACC, 32'h0, y);
  endtask

  task automatic reset_values();
    logic [7:0] ofs [10];
    logic [31:0] ev [10];
    ofs = '{OFS_THR1, OFS_THR2, OFS_CURVE1, OFS_DMODE, OFS_DTIME, OFS_TAU, OFS_GAIN,
            OFS_FMCUR, OFS_FMDEC, 8'h4C};
    ev = '{32'h400, 32'h400, 32'h0, 32'h0, 32'hEA60, 32'h3A98, 32'h3E8, 32'h400, 32'h5, 32'h0};
    foreach (ofs[i]) rchk(ofs[i], ev[i]);
    chk(32'(fm_cfg), {3'h0, 12'h400, 15'h0005, 2'h0});
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
  endtask

  // Out-of-range settings are clamped to the limits of each field.
  task automatic clamps();
    logic [7:0] ofs [6];
    logic [31:0] wv [6];
    logic [31:0] ev [6];
    ofs = '{OFS_THR1, OFS_THR1, OFS_FMCUR, OFS_FMCUR, OFS_FMDEC, OFS_FMDEC};
    wv = '{32'h10, 32'hFFF, 32'h0, 32'hFFF, 32'h0, 32'h7FFF};
    ev = '{32'hCD, 32'h400, 32'h148, 32'hCCD, 32'h1, 32'h7530};
    foreach (ofs[i]) begin
      wr(ofs[i], wv[i]);
      rchk(ofs[i], ev[i]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(OFS_FMSEL, 32'(c));
      rchk(OFS_FMSEL, (c == 3) ? 32'h2 : 32'(c));
      chk(32'(fm_cfg.start_sel), (c == 3) ? 32'h2 : 32'(c));
    end
    wr(OFS_CURVE1, 32'h3);
    rchk(OFS_CURVE1, 32'h2);
    wr(OFS_PT3, 32'hFFFF000);
    rchk(OFS_PT3, {4'h0, FREQ_MAX, 12'h000});
    wr(OFS_CURVE1, 32'h0);
  endtask

  task automatic trip_and_lock();
    wr(OFS_THR1, 32'h200);
    freq_set <= 16'h1388;
    demand <= 12'h200;
    ticks(5);
    rchk(OFS_MACC, 32'h0);
    demand <= 12'hFFF;
    for (int n = 0; n < 400 && motor_trip !== 1'b1; n++) @(negedge hclk);
    chk(32'(motor_output_en), 32'h0);
    rchk(OFS_FAULT, {16'h0000, 8'h01, ERR_MOTOR});
    rchk(OFS_MACC, {8'h00, ACC_FULL});
    rchk(OFS_STATUS, 32'h5);
    chk(32'(drive_trip), 32'h0);
    xfer(1'b0, OFS_DACC, 32'h0, rv);
    chk(32'(rv != 32'h0), 32'h1);
    demand <= 12'h000;
    wr(OFS_CTRL, 32'h2);
    ticks(1);
    chk(32'(motor_trip), 32'h1);
    ticks(1005);
    wr(OFS_CTRL, 32'h2);
    rchk(OFS_MACC, 32'h0);
    chk(32'(motor_trip), 32'h0);
    chk(32'(motor_output_en), 32'h1);
  endtask

  // Each decrement mode is judged over exactly one tick with the load removed.
  task automatic decrement_modes();
    logic [31:0] step;
    step = 32'(ACC_FULL) / 32'd10;
    wr(OFS_THR1, 32'h400);
    wr(OFS_DMODE, 32'h1);
    demand <= 12'hFFF;
    ticks(5);
    demand <= 12'h000;
    ticks(2);
    tick_pair(a, b);
    chk(b, a - 32'(LIN_STEP));
    wr(OFS_DMODE, 32'h0);
    tick_pair(a, b);
    chk(b, a);
    wr(OFS_TAU, 32'hA);
    wr(OFS_DMODE, 32'h3);
    tick_pair(a, b);
    chk(b, a - a / 32'd10);
    wr(OFS_DTIME, 32'hA);
    wr(OFS_DMODE, 32'h2);
    tick_pair(a, b);
    chk(b, (a > step) ? a - step : 32'h0);
    ticks(12);
    rchk(OFS_MACC, 32'h0);
    wr(OFS_DMODE, 32'h0);
  endtask

  // Load at 115 % of the second motor's level heats only that motor.
  task automatic second_motor();
    wr(OFS_THR2, 32'h200);
    demand <= 12'h24D;
    ticks(4);
    rchk(OFS_MACC, 32'h0);
    wr(OFS_CTRL, 32'h1);
    ticks(1);
    tick_pair(a, b);
    chk(b - a, 32'h4B32);
    rchk(OFS_STATUS, 32'h8);
    // Constant-torque curve at 2 Hz derates the level to 90 %, i.e. 12'h1CD.
    wr(OFS_CURVE2, 32'h1);
    freq_set <= 16'h00C8;
    ticks(1);
    tick_pair(a, b);
    chk(b - a, 32'h7D00);
    // Free curve, first point at 4 Hz and 50 %, sets the level to 12'h100.
    wr(OFS_PT1, 32'h00190200);
    wr(OFS_CURVE2, 32'h2);
    ticks(1);
    tick_pair(a, b);
    chk(b - a, 32'h14532);
  endtask

  // Drive overload alone: a minimal motor gain lets only the drive model trip.
  task automatic drive_overload();
    wr(OFS_GAIN, 32'hA);
    demand <= 12'hFFF;
    for (int n = 0; n < 400 && drive_trip !== 1'b1; n++) @(negedge hclk);
    chk(32'(drive_trip), 32'h1);
    chk(32'(motor_trip), 32'h0);
    chk(32'(motor_output_en), 32'h0);
    rchk(OFS_FAULT, {16'h0000, 8'h02, ERR_DRIVE});
    rchk(OFS_STATUS, 32'hE);
  endtask

  // Main sequence after an eight cycle reset.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    demand = 12'h000;
    freq_set = 16'h1388;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    clamps();
    trip_and_lock();
    decrement_modes();
    second_motor();
    drive_overload();
    complete_run();
  end
endmodule
